// ==== cmpl_checker.sv ====
`timescale 1ns/1ps
module cmpl_checker
(
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        doneValid,
   input wire logic [23:0] doneBlockAddr,
   input wire logic        doneReady,
   input wire logic        fetchReq,
   input wire logic [23:0] fetchAddr,
   input wire logic        fetchAck,
   input wire logic        wrReq,
   input wire logic        wrByte,
   input wire logic [31:0] wrAddr,
   input wire logic [31:0] wrData,
   input wire logic        wrAck,
   input wire logic        scsiRstOut
);
   logic [9:0] rstCnt_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Length of the bus reset drive
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n) rstCnt_q <= 10'h000;
      else rstCnt_q <= scsiRstOut ? rstCnt_q + 10'h001 : 10'h000;
   end
   a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack not a single pulse");
   a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   // Start pulse is registered, so the status write shows two edges after the accept
   a_status_first: assert property (doneValid && doneReady |-> ##2 wrReq && wrByte &&
      wrAddr == {8'h00, $past(doneBlockAddr, 2)} + 32'h0000_000E)
      else $error("status write wrong");
   a_entry_after: assert property (wrReq && wrByte && wrAck |=> wrReq && !wrByte &&
      wrData[31:24] == $past(wrData[7:0]) && wrData[23:0] == $past(wrAddr[23:0]) - 24'h00000E)
      else $error("mailbox entry wrong");
   a_write_hold: assert property (wrReq && !wrAck |=> wrReq && $stable(wrAddr) && $stable(wrData))
      else $error("memory write not held");
   a_fetch_hold: assert property (fetchReq && !fetchAck |=> fetchReq && $stable(fetchAddr))
      else $error("fetch request not held");
   a_busy_refuse: assert property (wrReq || fetchReq || scsiRstOut |-> !doneReady)
      else $error("ready while busy");
   a_reset_width: assert property ($fell(scsiRstOut) |-> rstCnt_q == 10'h271)
      else $error("bus reset width wrong");
   c_accept: cover property (doneValid && doneReady);
   c_fetch: cover property (fetchReq && fetchAck);
   c_busrst: cover property ($rose(scsiRstOut));
endmodule : cmpl_checker
bind linked_command_completion_status cmpl_checker u_cmpl_checker (.core_clk, .rst_n, .wb_cyc_i,
   .wb_stb_i, .wb_dat_o, .wb_ack_o, .doneValid, .doneBlockAddr, .doneReady, .fetchReq, .fetchAddr,
   .fetchAck, .wrReq, .wrByte, .wrAddr, .wrData, .wrAck, .scsiRstOut);

// ==== completion_poster.sv ====
`timescale 1ns/1ps
`include "link_done_cfg.svh"
module completion_poster
(
   input  wire logic  core_clk,
   input  wire logic  rst_n,
   post_if.poster     pst,
   output logic       wrReq,
   output logic       wrByte,
   output logic [31:0] wrAddr,
   output logic [31:0] wrData,
   input  wire logic  wrAck
);

   link_done_pkg::post_state_t state_q;
   logic                       done_q;

   assign pst.done = done_q;

   // Status byte first, mailbox entry second, so the host never sees stale status
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= link_done_pkg::PST_IDLE;
         wrReq   <= 1'b0;
         wrByte  <= 1'b0;
         wrAddr  <= 32'h0000_0000;
         wrData  <= 32'h0000_0000;
         done_q  <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         case (state_q)
            link_done_pkg::PST_IDLE:
               if (pst.start)
               begin
                  state_q <= link_done_pkg::PST_STATUS;
                  wrReq   <= 1'b1;
                  wrByte  <= 1'b1;
                  wrAddr  <= {8'h00, pst.blockAddr} + `CB_STATUS_BYTE;
                  wrData  <= {24'h00_0000, pst.code};
               end
            link_done_pkg::PST_STATUS:
               if (wrAck)
               begin
                  state_q <= link_done_pkg::PST_MAILBOX;
                  wrByte  <= 1'b0;
                  wrAddr  <= pst.mbxAddr;
                  wrData  <= {pst.code, pst.blockAddr};
               end
            link_done_pkg::PST_MAILBOX:
               if (wrAck)
               begin
                  state_q <= link_done_pkg::PST_IDLE;
                  wrReq   <= 1'b0;
                  done_q  <= 1'b1;
               end
            default:
               state_q <= link_done_pkg::PST_IDLE;
         endcase
      end
   end

endmodule : completion_poster

// ==== host_mem_model.sv ====
`timescale 1ns/1ps
module host_mem_model
(
   input  wire logic        core_clk,
   input  wire logic        slow,
   input  wire logic        wrReq,
   input  wire logic        wrByte,
   input  wire logic [31:0] wrAddr,
   input  wire logic [31:0] wrData,
   output logic             wrAck,
   input  wire logic        fetchReq,
   input  wire logic [23:0] fetchAddr,
   output logic             fetchAck
);
   logic [3:0]  waitCnt = 4'h0;
   logic [31:0] stAddr, enAddr, enData;
   logic [23:0] lastFetch;
   logic [7:0]  stCode;
   logic        haveStatus = 1'b0;
   logic        orderErr = 1'b0;
   wire         pend = (wrReq && !wrAck) || (fetchReq && !fetchAck);
   initial wrAck = 1'b0;
   initial fetchAck = 1'b0;
   // One-cycle acks; slow mode makes the design wait on every access
   always @(posedge core_clk)
   begin
      wrAck <= 1'b0;
      fetchAck <= 1'b0;
      waitCnt <= pend ? waitCnt + 4'h1 : 4'h0;
      if (pend && waitCnt == (slow ? 4'h5 : 4'h0))
      begin
         wrAck <= wrReq;
         fetchAck <= fetchReq;
         waitCnt <= 4'h0;
      end
      if (wrAck && wrByte) {stAddr, stCode} <= {wrAddr, wrData[7:0]};
      if (wrAck && !wrByte) {enAddr, enData} <= {wrAddr, wrData};
      if (wrAck) haveStatus <= wrByte;
      orderErr <= orderErr | (wrAck && !wrByte && !haveStatus);
      if (fetchAck) lastFetch <= fetchAddr;
   end
endmodule : host_mem_model

// ==== link_done_cfg.svh ====
`ifndef LINK_DONE_CFG_SVH
`define LINK_DONE_CFG_SVH

// Register byte offsets
`define REG_CTRL          8'h00
`define REG_IRQ_STATUS    8'h04
`define REG_IRQ_MASK      8'h08
`define REG_MBX_BASE      8'h0C
`define REG_MBX_COUNT     8'h10
`define REG_MBX_INDEX     8'h14
`define REG_LAST_RESULT   8'h18

// Field positions
`define CTRL_ENABLE_BIT   0
`define IRQ_MBX_BIT       0
`define IRQ_BUSRST_BIT    1
`define IRQ_WIDTH         2

// Reset values
`define CTRL_RESET        1'b0
`define MASK_RESET        2'h0
`define MBX_BASE_RESET    32'h0000_0000
`define MBX_COUNT_RESET   8'h01

// Command block layout and mailbox entry size
`define CB_STATUS_BYTE    32'h0000_000E
`define MBX_ENTRY_BYTES   32'h0000_0004

// Host status codes
`define HS_OK             8'h00
`define HS_LINKED         8'h0A
`define HS_LINKED_FLAG    8'h0B
`define HS_SEL_TIMEOUT    8'h11
`define HS_DATA_RUN       8'h12
`define HS_BUS_FREE       8'h13
`define HS_BAD_PHASE      8'h14

// Timing: bus reset hold
`define CLK_PERIOD_NS     40
`define BUS_RST_HOLD_NS   25000
`define BUS_RST_CYCLES    ((`BUS_RST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== link_done_pkg.sv ====
package link_done_pkg;

   // Outcome of one command as reported by the bus engine
   typedef enum logic [2:0] {
      OUT_GOOD,
      OUT_SEL_TIMEOUT,
      OUT_DATA_RUN,
      OUT_BUS_FREE,
      OUT_BAD_PHASE
   } outcome_t;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_POST,
      SEQ_FETCH,
      SEQ_BUSRST
   } seq_state_t;

   typedef enum logic [1:0] {
      PST_IDLE,
      PST_STATUS,
      PST_MAILBOX
   } post_state_t;

endpackage : link_done_pkg

// ==== linked_command_completion_status.sv ====
// Chosen here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "link_done_cfg.svh"
// Functional notes
// - Linked completion fetches next block at pointer
// - Link flag raises interrupt before next command
// - Every completed block posted to a mailbox
// - Mailbox interrupt only at chain end/flag
// - Status code written to block byte 14
// - Normal completion reports 00h
// - Linked clean completion reports 0Ah
// - Linked with flag message reports 0Bh, interrupts
// - Selection or reselection timeout reports 11h
// - Data overrun or underrun reports 12h
// - Invalid phase request reports 14h
// - Invalid phase drives bus reset, reset interrupt
module linked_command_completion_status
(
   input  wire logic                    core_clk,
   input  wire logic                    rst_n,
   // Wishbone slave
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [7:0]              wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic [31:0]                  wb_dat_o,
   output logic                         wb_ack_o,
   // Completion report from the bus engine
   input  wire logic                    doneValid,
   input  wire link_done_pkg::outcome_t doneOutcome,
   input  wire logic                    doneFlagMsg,
   input  wire logic [23:0]             doneBlockAddr,
   input  wire logic                    doneLink,
   input  wire logic                    doneLinkTag,
   input  wire logic                    doneLinkFlag,
   input  wire logic [23:0]             doneLinkPtr,
   input  wire logic [7:0]              doneLinkId,
   output logic                         doneReady,
   // Next command block fetch
   output logic                         fetchReq,
   output logic [23:0]                  fetchAddr,
   input  wire logic                    fetchAck,
   // Host memory write port
   output logic                         wrReq,
   output logic                         wrByte,
   output logic [31:0]                  wrAddr,
   output logic [31:0]                  wrData,
   input  wire logic                    wrAck,
   // Bus reset drive and interrupt
   output logic                         scsiRstOut,
   output logic                         irq
);

   // Hold length rounded up so the reset drive is never short
   localparam logic [9:0] RST_CYCLES = 10'(`BUS_RST_CYCLES);

   // Poster handshake; the ring index moves only once done is seen
   post_if pst ();

   // Register state
   logic                       enable_q;
   logic [`IRQ_WIDTH-1:0]      irqStatus_q;
   logic [`IRQ_WIDTH-1:0]      irqMask_q;
   logic [31:0]                mbxBase_q;
   logic [7:0]                 mbxCount_q;
   logic [7:0]                 mbxIndex_q;
   logic [31:0]                rdData_d;
   // Sequencer state
   link_done_pkg::seq_state_t  state_q;
   logic [7:0]                 code_q;
   logic [7:0]                 linkId_q;
   logic [23:0]                blockAddr_q;
   logic [23:0]                linkPtr_q;
   logic                       chainGoes_q;
   logic                       irqDue_q;
   logic                       badPhase_q;
   logic                       start_q;
   logic [9:0]                 rstCnt_q;

   // Map an outcome and the link bits onto the host status code
   function automatic logic [7:0] statusCode(input link_done_pkg::outcome_t oc,
                                             input logic linked, input logic flagged);
      case (oc)
         link_done_pkg::OUT_SEL_TIMEOUT: statusCode = `HS_SEL_TIMEOUT;
         link_done_pkg::OUT_DATA_RUN:    statusCode = `HS_DATA_RUN;
         link_done_pkg::OUT_BUS_FREE:    statusCode = `HS_BUS_FREE;
         link_done_pkg::OUT_BAD_PHASE:   statusCode = `HS_BAD_PHASE;
         default:
            if (!linked)
               statusCode = `HS_OK;
            else if (flagged)
               statusCode = `HS_LINKED_FLAG;
            else
               statusCode = `HS_LINKED;
      endcase
   endfunction : statusCode

   // Bus decode
   // Ack low in the request term keeps a held cycle from being taken twice
   wire        wbReq     = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire        wbWr      = wbReq && wb_we_i;
   wire        selLow    = wb_sel_i[0];
   wire        wrCtrl    = wbWr && selLow && (wb_adr_i == `REG_CTRL);
   wire        wrStatus  = wbWr && selLow && (wb_adr_i == `REG_IRQ_STATUS);
   wire        wrMask    = wbWr && selLow && (wb_adr_i == `REG_IRQ_MASK);
   wire        wrBase    = wbWr && (wb_adr_i == `REG_MBX_BASE);
   wire        wrCount   = wbWr && selLow && (wb_adr_i == `REG_MBX_COUNT);

   // Completion decode; errors always end the chain
   // A link-with-tag block chains exactly like a plain linked one
   wire        inLinked  = doneLink || doneLinkTag;
   wire        inFlagged = doneFlagMsg || doneLinkFlag;
   wire        inGood    = (doneOutcome == link_done_pkg::OUT_GOOD);
   wire        accept    = doneValid && doneReady;
   wire        postDone  = (state_q == link_done_pkg::SEQ_POST) && pst.done;

   // Interrupt events
   // Raised only once the mailbox entry is in memory, never ahead of it
   wire        mbxEvt    = postDone && irqDue_q;
   wire        rstEvt    = postDone && badPhase_q;
   wire [`IRQ_WIDTH-1:0] irqSet = {rstEvt, mbxEvt};
   wire [`IRQ_WIDTH-1:0] irqClr = wrStatus ? wb_dat_i[`IRQ_WIDTH-1:0] : '0;

   // Next mailbox slot wraps at the programmed count; a count of zero acts as one
   // Limitation: shrinking the count mid-chain restarts the ring at slot zero
   wire        idxWrap   = (mbxIndex_q + 8'h01 >= mbxCount_q);
   wire [7:0]  idxNext   = idxWrap ? 8'h00 : mbxIndex_q + 8'h01;

   assign pst.start     = start_q;
   assign pst.blockAddr = blockAddr_q;
   assign pst.code      = code_q;
   assign pst.mbxAddr   = mbxBase_q + 32'(mbxIndex_q) * `MBX_ENTRY_BYTES;

   // Read mux; unmapped offsets read zero
   // Busy bit lets software see a completion still in flight
   always_comb
   begin
      rdData_d = 32'h0000_0000;
      case (wb_adr_i)
         `REG_CTRL:        rdData_d = {31'h0, enable_q};
         `REG_IRQ_STATUS:  rdData_d = {30'h0, irqStatus_q};
         `REG_IRQ_MASK:    rdData_d = {30'h0, irqMask_q};
         `REG_MBX_BASE:    rdData_d = mbxBase_q;
         `REG_MBX_COUNT:   rdData_d = {24'h00_0000, mbxCount_q};
         `REG_MBX_INDEX:   rdData_d = {24'h00_0000, mbxIndex_q};
         `REG_LAST_RESULT: rdData_d = {15'h0000, (state_q != link_done_pkg::SEQ_IDLE),
                                       linkId_q, code_q};
         default:          rdData_d = 32'h0000_0000;
      endcase
   end

   // One wait state on every access; ack drops the cycle after
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= wbReq;
         wb_dat_o <= wbReq ? rdData_d : 32'h0000_0000;
      end
   end

   // Software registers; the base honours every byte lane
   // Narrow registers need lane zero; other lanes alone are ignored
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         enable_q   <= `CTRL_RESET;
         irqMask_q  <= `MASK_RESET;
         mbxBase_q  <= `MBX_BASE_RESET;
         mbxCount_q <= `MBX_COUNT_RESET;
      end
      else
      begin
         if (wrCtrl)
            enable_q <= wb_dat_i[`CTRL_ENABLE_BIT];
         if (wrMask)
            irqMask_q <= wb_dat_i[`IRQ_WIDTH-1:0];
         if (wrCount)
            mbxCount_q <= wb_dat_i[7:0];
         for (int b = 0; b < 4; b++)
            if (wrBase && wb_sel_i[b])
               mbxBase_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
      end
   end

   // Sticky status; a new event beats a write-one clear in the same cycle
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irqStatus_q <= '0;
         irq         <= 1'b0;
      end
      else
      begin
         irqStatus_q <= (irqStatus_q & ~irqClr) | irqSet;
         irq         <= |(((irqStatus_q & ~irqClr) | irqSet) & irqMask_q);
      end
   end

   // Completion sequencer
   // Ready is withheld while posting, fetching or resetting, so offers wait
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q     <= link_done_pkg::SEQ_IDLE;
         doneReady   <= 1'b0;
         code_q      <= `HS_OK;
         linkId_q    <= 8'h00;
         blockAddr_q <= 24'h00_0000;
         linkPtr_q   <= 24'h00_0000;
         chainGoes_q <= 1'b0;
         irqDue_q    <= 1'b0;
         badPhase_q  <= 1'b0;
         start_q     <= 1'b0;
         fetchReq    <= 1'b0;
         fetchAddr   <= 24'h00_0000;
         scsiRstOut  <= 1'b0;
         rstCnt_q    <= 10'h000;
         mbxIndex_q  <= 8'h00;
      end
      else
      begin
         start_q <= 1'b0;
         case (state_q)
            link_done_pkg::SEQ_IDLE:
            begin
               doneReady <= enable_q;
               if (accept)
               begin
                  state_q     <= link_done_pkg::SEQ_POST;
                  doneReady   <= 1'b0;
                  code_q      <= statusCode(doneOutcome, inLinked, inFlagged);
                  linkId_q    <= doneLinkId;
                  blockAddr_q <= doneBlockAddr;
                  linkPtr_q   <= doneLinkPtr;
                  chainGoes_q <= inGood && inLinked;
                  irqDue_q    <= !(inGood && inLinked) || inFlagged;
                  badPhase_q  <= (doneOutcome == link_done_pkg::OUT_BAD_PHASE);
                  start_q     <= 1'b1;
               end
            end
            link_done_pkg::SEQ_POST:
               if (pst.done)
               begin
                  mbxIndex_q <= idxNext;
                  if (badPhase_q)
                  begin
                     state_q    <= link_done_pkg::SEQ_BUSRST;
                     scsiRstOut <= 1'b1;
                     rstCnt_q   <= RST_CYCLES;
                  end
                  else if (chainGoes_q)
                  begin
                     // A flagged block's interrupt bit is set this edge, the same edge the fetch request rises
                     state_q   <= link_done_pkg::SEQ_FETCH;
                     fetchReq  <= 1'b1;
                     fetchAddr <= linkPtr_q;
                  end
                  else
                     state_q <= link_done_pkg::SEQ_IDLE;
               end
            link_done_pkg::SEQ_FETCH:
               if (fetchAck)
               begin
                  fetchReq <= 1'b0;
                  state_q  <= link_done_pkg::SEQ_IDLE;
               end
            // Count the hold down; ready stays low until the bus is released
            link_done_pkg::SEQ_BUSRST:
               if (rstCnt_q == 10'h001)
               begin
                  scsiRstOut <= 1'b0;
                  state_q    <= link_done_pkg::SEQ_IDLE;
               end
               else
                  rstCnt_q <= rstCnt_q - 10'h001;
            default:
               state_q <= link_done_pkg::SEQ_IDLE;
         endcase
      end
   end

   // Status byte and mailbox writer
   completion_poster u_completion_poster
   (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .pst      (pst),
      .wrReq    (wrReq),
      .wrByte   (wrByte),
      .wrAddr   (wrAddr),
      .wrData   (wrData),
      .wrAck    (wrAck)
   );

endmodule : linked_command_completion_status

// ==== post_if.sv ====
`timescale 1ns/1ps
interface post_if;
   logic        start;
   logic [23:0] blockAddr;
   logic [7:0]  code;
   logic [31:0] mbxAddr;
   logic        done;

   modport master (output start, output blockAddr, output code, output mbxAddr, input done);
   modport poster (input start, input blockAddr, input code, input mbxAddr, output done);
endinterface : post_if

// ==== tb_linked_command_completion_status.sv ====
`timescale 1ns/1ps
`include "link_done_cfg.svh"
module tb_linked_command_completion_status;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        wbCyc = 1'b0;
   logic        wbWe = 1'b0;
   logic [7:0]  wbAdr = 8'h00;
   logic [31:0] wbDatI = 32'h0;
   logic [31:0] wbDatO, wrAddr, wrData, rd;
   logic        wbAck, doneReady, fetchReq, fetchAck, wrReq, wrByte, wrAck, scsiRstOut, irq;
   logic        dv = 1'b0;
   logic [3:0]  dFl = 4'h0;
   logic [23:0] dBlk = 24'h0, fetchAddr;
   logic [7:0]  n = 8'h00;
   logic        slowMode = 1'b0;
   link_done_pkg::outcome_t dOut = link_done_pkg::OUT_GOOD;
   int          bad_count = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   link_done_pkg::outcome_t oc[8] = '{link_done_pkg::OUT_GOOD, link_done_pkg::OUT_GOOD,
      link_done_pkg::OUT_GOOD, link_done_pkg::OUT_GOOD, link_done_pkg::OUT_SEL_TIMEOUT,
      link_done_pkg::OUT_DATA_RUN, link_done_pkg::OUT_BUS_FREE, link_done_pkg::OUT_BAD_PHASE};
   // Flag bits: tag, link, link flag, flag message
   logic [3:0]  fl[8] = '{4'h0, 4'h4, 4'h6, 4'h9, 4'h4, 4'h0, 4'h0, 4'h0};
   logic [7:0]  cd[8] = '{`HS_OK, `HS_LINKED, `HS_LINKED_FLAG, `HS_LINKED_FLAG, `HS_SEL_TIMEOUT,
      `HS_DATA_RUN, `HS_BUS_FREE, `HS_BAD_PHASE};
   logic [1:0]  iq[8] = '{2'h1, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h3};
   logic [7:0]  ra[5] = '{`REG_CTRL, `REG_IRQ_MASK, `REG_MBX_BASE, `REG_MBX_COUNT, 8'h1C};
   logic [31:0] rv[5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
   always #20 core_clk = ~core_clk;
   // Design under test; one chained block uses the link-with-tag bit
   linked_command_completion_status u_linked_command_completion_status (.core_clk, .rst_n,
      .wb_cyc_i(wbCyc), .wb_stb_i(wbCyc), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
      .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .doneValid(dv), .doneOutcome(dOut),
      .doneFlagMsg(dFl[0]), .doneBlockAddr(dBlk), .doneLink(dFl[2]), .doneLinkTag(dFl[3]),
      .doneLinkFlag(dFl[1]), .doneLinkPtr(dBlk + 24'h000040), .doneLinkId(8'h5A),
      .doneReady, .fetchReq, .fetchAddr, .fetchAck, .wrReq, .wrByte, .wrAddr, .wrData, .wrAck,
      .scsiRstOut, .irq);
   host_mem_model u_host_mem_model (.core_clk, .slow(slowMode), .wrReq, .wrByte, .wrAddr,
      .wrData, .wrAck, .fetchReq, .fetchAddr, .fetchAck);
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Classic single Wishbone cycle; the answer is taken at the ack edge
   task automatic wbXfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      {wbCyc, wbWe, wbAdr, wbDatI} <= {1'b1, w, a, d};
      do @(posedge core_clk); while (wbAck !== 1'b1);
      rd = wbDatO;
      {wbCyc, wbWe} <= 2'h0;
   endtask : wbXfer
   // Offer one completion, then wait until the sequencer is idle again
   task automatic offer(input int i, input logic [23:0] blk);
      @(posedge core_clk);
      {dv, dOut, dFl, dBlk} <= {1'b1, oc[i], fl[i], blk};
      do @(posedge core_clk); while (doneReady !== 1'b1);
      dv <= 1'b0;
      do @(posedge core_clk); while (doneReady !== 1'b1);
   endtask : offer
   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : conclude
   // Cycle ceiling well above the longest expected run
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         conclude;
      end
   end
   initial
   begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int r = 0; r < 5; r++)
      begin
         wbXfer(1'b0, ra[r], 32'h0);
         check("reset value", rd, rv[r]);
      end
      wbXfer(1'b1, `REG_MBX_BASE, 32'h0000_1000);
      wbXfer(1'b1, `REG_MBX_COUNT, 32'h4);
      wbXfer(1'b1, `REG_IRQ_MASK, 32'h3);
      wbXfer(1'b1, `REG_CTRL, 32'h1);
      $display("test registers done");
      for (int i = 0; i < 9; i++)
      begin
         slowMode <= i[0];
         offer(i % 8, 24'h012300 + 24'(i * 32));
         check("status addr", u_host_mem_model.stAddr, 32'h0001_230E + 32'(i * 32));
         check("status code", u_host_mem_model.stCode, cd[i % 8]);
         check("entry data", u_host_mem_model.enData, {cd[i % 8], 24'h012300 + 24'(i * 32)});
         check("entry addr", u_host_mem_model.enAddr, 32'h1000 + {28'h0, n[1:0], 2'h0});
         n = n + 8'h01;
         wbXfer(1'b0, `REG_MBX_INDEX, 32'h0);
         check("mailbox index", rd, {30'h0, n[1:0]});
         if (|fl[i % 8][3:2] && i < 4) check("fetch", u_host_mem_model.lastFetch,
            24'h012340 + 24'(i * 32));
         wbXfer(1'b0, `REG_LAST_RESULT, 32'h0);
         check("last result", rd[16:0], {9'h05A, cd[i % 8]});
         if (i == 8) wbXfer(1'b1, `REG_IRQ_MASK, 32'h3);
         wbXfer(1'b0, `REG_IRQ_STATUS, 32'h0);
         check("irq status", rd, iq[i % 8]);
         check("irq pin", irq, |iq[i % 8]);
         wbXfer(1'b1, `REG_IRQ_STATUS, 32'h3);
         wbXfer(1'b0, `REG_IRQ_STATUS, 32'h0);
         check("irq clear", rd, 32'h0);
         if (i == 7)
         begin
            wbXfer(1'b1, `REG_IRQ_MASK, 32'h0);
            offer(0, 24'h012400);
            check("masked irq", irq, 1'b0);
            wbXfer(1'b1, `REG_IRQ_STATUS, 32'h3);
            n = n + 8'h01;
         end
         $display("test completion %0d done", i);
      end
      check("order", u_host_mem_model.orderErr, 1'b0);
      conclude;
   end
endmodule : tb_linked_command_completion_status
